// file: verilog/poll_field_cmd.v
// Summary of operation
// (R1) Request is 0x03, length, then parameters
// (R2) Length zero reports field at once
// (R3) Every accepted request answers field-present flag, except a bad-length reply (82 00) and a short-mode no-field reply (00 00)
// (R4) Condition byte: 01 appear, 00 disappear
// (R5) Waiting stops when timeout elapses
// (R6) Timeout is (presc+1)*(timer+1) reference periods
// (R7) Host sends condition, prescaler, timer together
// (R8) No field may reply as 00 00
// (R9) Full reply 00 01 status, bit0 field
// (R10) Bad length replies 82 00
// (R11) Reader mode forces field flag to one
// (R12) Wait reply uses flag sampled at end
`timescale 1ns/100ps
`include "poll_field_consts.vh"

module poll_field_cmd (
    input  wire        i_clk,
    input  wire        i_rstn,
    // Command byte stream from the host interface
    input  wire        i_cmd_valid,
    input  wire [7:0]  i_cmd_byte,
    output wire        o_cmd_ready,
    // Reply byte stream to the host interface
    output wire        o_rsp_valid,
    output reg  [7:0]  o_rsp_byte,
    input  wire        i_rsp_ready,
    // Analog field detector level
    input  wire        i_field_det,
    // Avalon-MM slave
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest
);

    localparam [2:0] S_CMD   = 3'd0;
    localparam [2:0] S_LEN   = 3'd1;
    localparam [2:0] S_PARAM = 3'd2;
    localparam [2:0] S_SKIP  = 3'd3;
    localparam [2:0] S_WAIT  = 3'd4;
    localparam [2:0] S_RSP   = 3'd5;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [7:0]  len_q;
    reg  [7:0]  len_d;
    reg  [1:0]  pidx_q;
    reg  [1:0]  pidx_d;
    reg  [7:0]  cond_q;
    reg  [7:0]  cond_d;
    reg  [7:0]  presc_q;
    reg  [7:0]  presc_d;
    reg  [7:0]  timer_q;
    reg  [7:0]  timer_d;
    reg  [7:0]  pcnt_q;
    reg  [7:0]  pcnt_d;
    reg  [7:0]  tcnt_q;
    reg  [7:0]  tcnt_d;
    reg  [23:0] rbuf_q;
    reg  [23:0] rbuf_d;
    reg  [1:0]  rlen_q;
    reg  [1:0]  rlen_d;
    reg  [1:0]  ridx_q;
    reg  [1:0]  ridx_d;
    reg         tout_q;
    reg         tout_d;
    reg  [23:0] last_q;
    reg  [15:0] count_q;
    reg  [1:0]  ctrl_q;
    reg         ack_q;
    reg  [17:0] phase_q;
    reg  [17:0] phase_d;
    reg         ref_tick;
    reg  [31:0] rdata_d;

    wire        field_flag;
    wire        cmd_fire;
    wire        rsp_fire;
    wire        want_field;
    wire        cond_met;
    wire        tout_hit;
    wire        bus_req;
    wire        skip_done;
    wire        rsp_last;

    // A byte offered after the last skipped one would be lost, so hold ready low then
    assign skip_done   = (len_q == 8'h00);
    assign o_cmd_ready = (state_q == S_CMD) || (state_q == S_LEN) ||
                         (state_q == S_PARAM) || ((state_q == S_SKIP) && !skip_done);
    assign rsp_last    = (ridx_q == rlen_q - 2'd1);
    assign cmd_fire    = i_cmd_valid & o_cmd_ready;
    assign o_rsp_valid = (state_q == S_RSP);
    assign rsp_fire    = o_rsp_valid & i_rsp_ready;

    // Own transmitter holds the field up whenever reader mode is selected
    assign field_flag  = i_field_det | ctrl_q[`CTRL_READER_BIT]; // (R11)

    // Condition bytes other than 01 are taken as a wait for disappearance
    assign want_field  = (cond_q == `COND_APPEAR); // (R4)
    assign cond_met    = (field_flag == want_field); // (R4)

    // Last reference tick of the last prescaler round of the last timer step
    assign tout_hit    = ref_tick && (pcnt_q == presc_q) && (tcnt_q == timer_q); // (R6)

    // Fractional divider: one tick per field reference period on average
    always @* begin
        phase_d  = phase_q + `REF_RATE_KHZ;
        ref_tick = 1'b0;
        if (phase_d >= `CLK_RATE_KHZ) begin
            phase_d  = phase_d - `CLK_RATE_KHZ;
            ref_tick = 1'b1;
        end
    end

    always @* begin
        state_d = state_q;
        len_d   = len_q;
        pidx_d  = pidx_q;
        cond_d  = cond_q;
        presc_d = presc_q;
        timer_d = timer_q;
        pcnt_d  = pcnt_q;
        tcnt_d  = tcnt_q;
        rbuf_d  = rbuf_q;
        rlen_d  = rlen_q;
        ridx_d  = ridx_q;
        tout_d  = tout_q;
        case (state_q)
            S_CMD: begin
                // Bytes of other commands are not ours and are dropped singly
                if (cmd_fire && (i_cmd_byte == `CMD_POLL_FIELD)) begin
                    state_d = S_LEN; // (R1)
                end
            end
            S_LEN: begin
                if (cmd_fire) begin
                    len_d  = i_cmd_byte; // (R1)
                    pidx_d = 2'd0;
                    if (i_cmd_byte == `LEN_IMMEDIATE) begin
                        state_d = S_RSP; // (R2)
                        tout_d  = 1'b0;
                        ridx_d  = 2'd0;
                        if (!field_flag && ctrl_q[`CTRL_SHORT_BIT]) begin
                            rbuf_d = {`RES_OK, `LEN_NONE, 8'h00}; // (R8)
                            rlen_d = 2'd2;
                        end else begin
                            rbuf_d = {`RES_OK, `LEN_ONE, 7'h00, field_flag}; // (R3) (R9)
                            rlen_d = 2'd3;
                        end
                    end else if (i_cmd_byte == `LEN_WAIT) begin
                        state_d = S_PARAM; // (R7)
                    end else begin
                        // Parameters of a bad request are swallowed before the error
                        state_d = S_SKIP; // (R10)
                    end
                end
            end
            S_PARAM: begin
                if (cmd_fire) begin
                    pidx_d = pidx_q + 2'd1;
                    // Counters restart per request, so an old wait leaves nothing behind
                    case (pidx_q)
                        2'd0:    cond_d  = i_cmd_byte; // (R4)
                        2'd1:    presc_d = i_cmd_byte; // (R6)
                        default: begin
                            timer_d = i_cmd_byte; // (R6)
                            pcnt_d  = 8'h00;
                            tcnt_d  = 8'h00;
                            state_d = S_WAIT;
                        end
                    endcase
                end
            end
            S_SKIP: begin
                if (skip_done) begin
                    state_d = S_RSP;
                    rbuf_d  = {`RES_BAD_LEN, `LEN_NONE, 8'h00}; // (R10)
                    rlen_d  = 2'd2;
                    ridx_d  = 2'd0;
                end else if (cmd_fire) begin
                    len_d = len_q - 8'h01;
                end
            end
            S_WAIT: begin
                // Counters advance only on reference ticks
                if (ref_tick) begin
                    if (pcnt_q == presc_q) begin
                        pcnt_d = 8'h00;
                        tcnt_d = tcnt_q + 8'h01; // (R6)
                    end else begin
                        pcnt_d = pcnt_q + 8'h01; // (R6)
                    end
                end
                if (cond_met || tout_hit) begin
                    state_d = S_RSP; // (R5)
                    tout_d  = ~cond_met & tout_hit;
                    ridx_d  = 2'd0;
                    // Flag taken in the very cycle the wait ends
                    if (!field_flag && ctrl_q[`CTRL_SHORT_BIT]) begin
                        rbuf_d = {`RES_OK, `LEN_NONE, 8'h00}; // (R8) (R12)
                        rlen_d = 2'd2;
                    end else begin
                        rbuf_d = {`RES_OK, `LEN_ONE, 7'h00, field_flag}; // (R3) (R12)
                        rlen_d = 2'd3;
                    end
                end
            end
            S_RSP: begin
                if (rsp_fire) begin
                    ridx_d = ridx_q + 2'd1;
                    // Reply ends when its last byte is taken
                    if (rsp_last) begin
                        state_d = S_CMD;
                    end
                end
            end
            default: begin
                state_d = S_CMD;
            end
        endcase
    end

    // Request decoding state
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= S_CMD;
            len_q   <= 8'h00;
            pidx_q  <= 2'd0;
        end else begin
            state_q <= state_d;
            len_q   <= len_d;
            pidx_q  <= pidx_d;
        end
    end

    // Wait parameters stay as last received; only a new request replaces them
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cond_q  <= 8'h00;
            presc_q <= 8'h00;
            timer_q <= 8'h00;
        end else begin
            cond_q  <= cond_d;
            presc_q <= presc_d;
            timer_q <= timer_d;
        end
    end

    // Divider runs freely, so a wait may start at any reference phase
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pcnt_q  <= 8'h00;
            tcnt_q  <= 8'h00;
            phase_q <= 18'h00000;
        end else begin
            pcnt_q  <= pcnt_d;
            tcnt_q  <= tcnt_d;
            phase_q <= phase_d;
        end
    end

    // Reply buffer and its progress
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rbuf_q  <= 24'h000000;
            rlen_q  <= 2'd0;
            ridx_q  <= 2'd0;
            tout_q  <= 1'b0;
        end else begin
            rbuf_q  <= rbuf_d;
            rlen_q  <= rlen_d;
            ridx_q  <= ridx_d;
            tout_q  <= tout_d;
        end
    end

    // Reply buffer seen as byte lanes, first byte in the top lane
    wire [7:0]  rsp_lane [0:2];
    genvar      gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_lane
            assign rsp_lane[gi] = rbuf_d[23 - 8 * gi -: 8];
        end
    endgenerate

    // Reply byte register follows the byte index, first byte highest
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rsp_byte <= 8'h00;
        end else begin
            case (ridx_d)
                2'd0:    o_rsp_byte <= rsp_lane[0];
                2'd1:    o_rsp_byte <= rsp_lane[1];
                default: o_rsp_byte <= rsp_lane[2];
            endcase
        end
    end

    // Record of the most recent reply, and a count of finished replies
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            last_q  <= 24'h000000;
            count_q <= 16'h0000;
        end else if (rsp_fire && rsp_last) begin
            last_q  <= rbuf_q;
            count_q <= count_q + 16'h0001;
        end
    end

    // Read word is chosen combinationally and registered on the request edge
    always @* begin
        case (i_avs_address)
            `REG_CTRL:       rdata_d = {30'h00000000, ctrl_q};
            `REG_STATUS:     rdata_d = {26'h0000000, state_q, tout_q,
                                        (state_q == S_WAIT), field_flag};
            `REG_LAST_REPLY: rdata_d = {8'h00, last_q};
            `REG_COUNT:      rdata_d = {16'h0000, count_q};
            default:         rdata_d = 32'h00000000;
        endcase
    end

    // Avalon slave: every access completes one cycle after it is presented
    assign bus_req           = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = bus_req & ~ack_q;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_q          <= 1'b0;
            ctrl_q         <= `CTRL_RESET;
            o_avs_readdata <= 32'h00000000;
        end else begin
            // Back-to-back requests see ack low again, so each waits one cycle
            ack_q <= bus_req & ~ack_q;
            if (i_avs_write && !ack_q && (i_avs_address == `REG_CTRL)) begin
                ctrl_q <= i_avs_writedata[1:0];
            end
            if (i_avs_read && !ack_q) begin
                o_avs_readdata <= rdata_d;
            end
        end
    end

endmodule

// file: verilog/poll_field_consts.vh
`ifndef POLL_FIELD_CONSTS_VH
`define POLL_FIELD_CONSTS_VH

// Command and reply bytes
`define CMD_POLL_FIELD    8'h03
`define LEN_IMMEDIATE     8'h00
`define LEN_WAIT          8'h03
`define COND_APPEAR       8'h01
`define COND_DISAPPEAR    8'h00
`define RES_OK            8'h00
`define RES_BAD_LEN       8'h82
`define LEN_NONE          8'h00
`define LEN_ONE           8'h01

// Status byte layout
`define STAT_FIELD_BIT    0

// Register byte addresses
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_LAST_REPLY    4'h8
`define REG_COUNT         4'hC

// Control fields and reset value
`define CTRL_READER_BIT   0
`define CTRL_SHORT_BIT    1
`define CTRL_RESET        2'h0

// Timing: clock and field reference rates in kHz
`define CLK_RATE_KHZ      18'd200000
`define REF_RATE_KHZ      18'd13560

`endif

// file: bench/poll_field_sva.sv
`timescale 1ns/100ps
module poll_field_sva (
    input wire logic       i_clk,
    input wire logic       i_rstn,
    input wire logic       i_cmd_valid,
    input wire logic [7:0] i_cmd_byte,
    input wire logic       o_cmd_ready,
    input wire logic       o_rsp_valid,
    input wire logic [7:0] o_rsp_byte,
    input wire logic       i_rsp_ready
);
    logic [1:0] pos_q;
    logic [2:0] req_q;
    logic [7:0] res_q;
    wire        tk = i_cmd_valid && o_cmd_ready;
    wire        rt = o_rsp_valid && i_rsp_ready;
    // Reply byte position and request byte count, so a length byte is not mistaken for a command
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pos_q <= 2'h0;
            req_q <= 3'h0;
            res_q <= 8'h0;
        end else begin
            pos_q <= !o_rsp_valid ? 2'h0 : pos_q + {1'b0, rt};
            req_q <= o_rsp_valid ? 3'h0 : req_q + {2'h0, tk && req_q != 3'h7};
            if (rt && pos_q == 2'h0)
                res_q <= o_rsp_byte;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_cmd;
        tk && i_cmd_byte == 8'h03 && req_q == 3'h0;
    endsequence
    sequence s_imm;
        s_cmd ##1 (tk && i_cmd_byte == 8'h00);
    endsequence
    sequence s_bad;
        s_cmd ##1 (tk && i_cmd_byte == 8'h01) ##1 tk;
    endsequence
    a_imm_answer: assert property (s_imm |=> o_rsp_valid && o_rsp_byte == 8'h00)
        else $error("immediate poll not answered next cycle");
    a_bad_len: assert property (s_bad |-> ##2 o_rsp_valid && o_rsp_byte == 8'h82)
        else $error("bad length not rejected");
    a_rsp_hold: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte))
        else $error("reply byte dropped before taken");
    a_no_cmd_reply: assert property (o_rsp_valid |-> !o_cmd_ready)
        else $error("command accepted while replying");
    a_result_code: assert property (o_rsp_valid && pos_q == 2'h0 |-> o_rsp_byte inside {8'h00, 8'h82})
        else $error("bad result code");
    a_err_len: assert property (o_rsp_valid && pos_q == 2'h1 && res_q == 8'h82 |-> o_rsp_byte == 8'h00)
        else $error("error reply length not zero");
    a_ok_len: assert property (o_rsp_valid && pos_q == 2'h1 && res_q == 8'h00 |-> o_rsp_byte inside {8'h00, 8'h01})
        else $error("reply length wrong");
    a_stat_rsvd: assert property (o_rsp_valid && pos_q == 2'h2 |-> o_rsp_byte[7:1] == 7'h0)
        else $error("status reserved bits set");
    a_reply_end: assert property (rt && (pos_q == 2'h2 || (pos_q == 2'h1 && (res_q != 8'h00 || o_rsp_byte == 8'h00))) |=> !o_rsp_valid)
        else $error("reply longer than its length");
endmodule

// file: bench/host_model.sv
`timescale 1ns/100ps
module host_model (
    input  wire       i_clk,
    input  wire       i_cmd_ready,
    output reg        o_cmd_valid,
    output reg  [7:0] o_cmd_byte,
    output reg        o_rsp_ready
);
    integer seed = 32'h5ce813bb;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_byte  = 8'hA5;
        o_rsp_ready = 1'b0;
    end
    // Random stalls on the reply side, so held reply bytes get exercised
    always @(posedge i_clk)
        o_rsp_ready <= ($random(seed) % 3) != 0;
    // Byte held until the rising edge at which ready is sampled high
    task automatic send(input logic [7:0] b);
        o_cmd_valid <= 1'b1;
        o_cmd_byte  <= b;
        @(posedge i_clk);
        while (!i_cmd_ready) @(posedge i_clk);
    endtask
    // Released byte lane must not keep showing the last value
    task automatic idle;
        o_cmd_valid <= 1'b0;
        o_cmd_byte  <= ~o_cmd_byte;
    endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        i_clk = 1'b0;
    logic        i_rstn, i_field_det, i_avs_read, i_avs_write;
    logic [3:0]  i_avs_address;
    logic [31:0] i_avs_writedata, q;
    wire         cmd_valid, cmd_ready, rsp_valid, rsp_ready, waitreq;
    wire  [7:0]  cmd_byte, rsp_byte;
    wire  [31:0] rdata;
    logic [7:0]  exp_q[$], b[$];
    int          n_fail = 0, total_checks = 0, cyc = 0, n, n_rep = 0;
    always #2.5 i_clk = ~i_clk;
    poll_field_cmd DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd_valid(cmd_valid),
        .i_cmd_byte(cmd_byte), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
        .o_rsp_byte(rsp_byte), .i_rsp_ready(rsp_ready), .i_field_det(i_field_det),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));
    host_model host (.i_clk(i_clk), .i_cmd_ready(cmd_ready), .o_cmd_valid(cmd_valid),
        .o_cmd_byte(cmd_byte), .o_rsp_ready(rsp_ready));
    task automatic print_verdict;
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        i_avs_read      <= !wr;
        i_avs_write     <= wr;
        i_avs_address   <= a;
        i_avs_writedata <= d;
        @(posedge i_clk);
        while (waitreq) @(posedge i_clk);
        q = rdata;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_clk);
    endtask
    // Sends one request, notes the reply, and counts cycles until the reply starts
    task automatic run(input logic [7:0] c[$], input logic [7:0] e[$]);
        foreach (e[i]) exp_q.push_back(e[i]);
        foreach (c[i]) host.send(c[i]);
        host.idle();
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (!rsp_valid);
        while (exp_q.size() != 0) @(negedge i_clk);
        @(posedge i_clk);
        n_rep++;
    endtask
    always @(posedge i_clk)
        if (i_rstn && rsp_valid && rsp_ready) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("[ERR] %0t reply byte with nothing expected", $time);
            end else
                cmp(rsp_byte, exp_q.pop_front());
        end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        i_rstn          = 1'b0;
        i_field_det     = 1'b0;
        i_avs_address   = 4'h0;
        i_avs_read      = 1'b0;
        i_avs_write     = 1'b0;
        i_avs_writedata = 32'h0;
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        bus(1'b0, 4'h0, 32'h0);
        cmp(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        cmp(q, 32'h0);
        for (int f = 0; f < 2; f++) begin
            i_field_det <= f[0];
            run({8'h03, 8'h00}, {8'h00, 8'h01, 8'(f[0])});
        end
        bus(1'b1, 4'h0, 32'h1);
        i_field_det <= 1'b0;
        run({8'h03, 8'h00}, {8'h00, 8'h01, 8'h01});
        bus(1'b1, 4'h0, 32'h2);
        run({8'h03, 8'h00}, {8'h00, 8'h00});
        i_field_det <= 1'b1;
        run({8'h03, 8'h00}, {8'h00, 8'h01, 8'h01});
        bus(1'b1, 4'h0, 32'h0);
        for (int l = 1; l < 5; l++) begin
            if (l != 3) begin
                b = {8'h03, 8'(l)};
                repeat (l) b.push_back(8'h5A);
                run(b, {8'h82, 8'h00});
            end
        end
        i_field_det <= 1'b0;
        run({8'h55, 8'h03, 8'h00}, {8'h00, 8'h01, 8'h00});
        for (int k = 0; k < 4; k++) begin
            i_field_det <= !k[0];
            fork
                if (k[1]) begin
                    repeat (20) @(posedge i_clk);
                    i_field_det <= k[0];
                end
                run({8'h03, 8'h03, 8'(k[0]), 8'h01, 8'h02},
                    {8'h00, 8'h01, 8'(k[1] ? k[0] : !k[0])});
            join
            cmp(k[1] ? n <= 25 : n >= 70 && n <= 93, 1);
            bus(1'b0, 4'h4, 32'h0);
            cmp(q, {29'h0, !k[1], 1'b0, k[1] ? k[0] : !k[0]});
        end
        bus(1'b0, 4'hC, 32'h0);
        cmp(q[15:0], n_rep[15:0]);
        bus(1'b0, 4'h8, 32'h0);
        cmp(q, 32'h00000101);
        print_verdict();
    end
endmodule
bind poll_field_cmd poll_field_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte), .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte), .i_rsp_ready(i_rsp_ready));
